/* File: pkg/cwd_defs.svh */
// Offsets, field positions, reset values and timing counts of the watchdog
`ifndef CWD_DEFS_SVH
`define CWD_DEFS_SVH

// ********************************************************************
// Register byte offsets
// ********************************************************************
`define CWD_ADDR_RATE 12'h000
`define CWD_ADDR_TEST 12'h004
`define CWD_ADDR_SERVICE 12'h008
`define CWD_ADDR_STATUS 12'h00c

// ********************************************************************
// Field positions
// ********************************************************************
`define CWD_TEST_INHIBIT_BIT 0
`define CWD_STAT_CAUSE_LSB 0
`define CWD_STAT_SPECIAL_BIT 2
`define CWD_STAT_ENABLED_BIT 3
`define CWD_STAT_LOCKED_BIT 4

// ********************************************************************
// Reset values and service keys
// ********************************************************************
`define CWD_RATE_RESET 2'h0
`define CWD_SERVICE_KEY1 8'h55
`define CWD_SERVICE_KEY2 8'haa

// ********************************************************************
// Timing counts, in bus (E) cycles; CWD_BUS_DIV counts ref_clk cycles per E cycle
// ********************************************************************
`define CWD_DRIVE_CYCLES 3'h4
`define CWD_SAMPLE_DELAY 3'h2
`define CWD_RATE_WINDOW 7'h40
`define CWD_BUS_DIV 4
`define CWD_BASE_DIV 32768

`endif

/* File: pkg/cwd_pkg.sv */
// Types shared by the watchdog and reset-sense logic
package cwd_pkg;

	typedef enum logic [1:0] {
		ST_DRIVE,
		ST_WAIT,
		ST_HOLD,
		ST_RUN
	} cwd_state_e;

	typedef enum logic [1:0] {
		CAUSE_NONE,
		CAUSE_EXT,
		CAUSE_WDOG,
		CAUSE_CLKMON
	} cwd_cause_e;

endpackage

/* File: core/cwd_divider.sv */
// Enable-driven divider that gives a one-cycle tick every DIV enables
module cwd_divider #(
	parameter int DIV = 4,
	parameter int W = 16
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic enable,
	output logic tick
);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	wire atTop = (cnt_r == W'(DIV - 1));

	assign tick = enable && atTop;
	assign cnt_nxt = atTop ? '0 : cnt_r + W'(1);

	always_ff @(posedge ref_clk) begin
		if (!reset_n || clear) begin
			cnt_r <= '0;
		end else if (enable) begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule

/* File: core/cwd_top.sv */
// Reset-source sensing and software watchdog with an APB register slave
//
// Function
// - Drive reset pin low four bus cycles
// - Sample pin two cycles later; low means external
// - Pin high means watchdog or clock monitor
// - Nonvolatile disable bit gates the watchdog
// - Enable change applies only after system reset
// - Special modes start inhibited; write 0 enables
// - Unserviced watchdog expiry starts system reset
// - Timeout is E over 2^15 times 1/4/16/64
// - Rate field resets to zero, shortest period
// - Normal modes: one rate write, first 64 cycles
// - Timeout up to one base period long, never short
// - Special flag latched as inverse of mode pin
//
// The APB slave port and the register addresses were left to the implementer.
`include "cwd_defs.svh"

module cwd_top #(
	parameter int BUS_DIV = `CWD_BUS_DIV,
	parameter int BASE_DIV = `CWD_BASE_DIV
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic resetPinIn,
	output logic resetPinOut,
	output logic resetPinOe,
	input wire logic mode_pin_b,
	input wire logic watchdog_disable_cfg,
	input wire logic clkMonFail,
	output logic sysReset_n,
	output cwd_pkg::cwd_cause_e resetCause,
	output logic special_mode_flag
);
	import cwd_pkg::*;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [6:0] rateFactor(input logic [1:0] sel);
		logic [6:0] f;
		f = 7'h01;
		unique case (sel)
			2'h0: f = 7'h01;
			2'h1: f = 7'h04;
			2'h2: f = 7'h10;
			2'h3: f = 7'h40;
		endcase
		return f;
	endfunction

	// ****************************************************************
	// Declarations
	// ****************************************************************
	cwd_state_e state_r;
	cwd_state_e state_nxt;
	cwd_cause_e pendCause_r;
	cwd_cause_e cause_r;
	logic [2:0] phaseCnt_r;
	logic pinS1_r;
	logic pinS2_r;
	logic pinS3_r;
	logic pinFilt_r;
	logic modeS1_r;
	logic modeS2_r;
	logic modeS3_r;
	logic modeFilt_r;
	logic specialMode_r;
	logic nvDisable_r;
	logic inhibit_r;
	logic [1:0] watchdog_rate_sel;
	logic rateWritten_r;
	logic [6:0] winCnt_r;
	logic [6:0] tickCnt_r;
	logic svcArmed_r;
	logic [31:0] prdata_r;
	logic eTick;
	logic baseTick;

	// ****************************************************************
	// Clock enables
	// ****************************************************************
	wire inRun = (state_r == ST_RUN);
	wire sysRst = !reset_n || !inRun;

	cwd_divider #(.DIV(BUS_DIV), .W(16)) busDiv (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.clear(1'b0),
		.enable(1'b1),
		.tick(eTick)
	);

	// Base period restarts with each release so it never runs short
	cwd_divider #(.DIV(BASE_DIV), .W(16)) baseDiv (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.clear(!inRun),
		.enable(eTick),
		.tick(baseTick)
	);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pinS1_r <= 1'b1;
			pinS2_r <= 1'b1;
			pinS3_r <= 1'b1;
			modeS1_r <= 1'b1;
			modeS2_r <= 1'b1;
			modeS3_r <= 1'b1;
		end else begin
			pinS1_r <= resetPinIn;
			pinS2_r <= pinS1_r;
			pinS3_r <= pinS2_r;
			modeS1_r <= mode_pin_b;
			modeS2_r <= modeS1_r;
			modeS3_r <= modeS2_r;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pinFilt_r <= 1'b1;
			modeFilt_r <= 1'b1;
		end else begin
			if (pinS2_r == pinS3_r) begin
				pinFilt_r <= pinS3_r;
			end
			if (modeS2_r == modeS3_r) begin
				modeFilt_r <= modeS3_r;
			end
		end
	end

	// ****************************************************************
	// Reset sequencer
	// ****************************************************************
	wire phaseDone4 = eTick && (phaseCnt_r == `CWD_DRIVE_CYCLES - 3'h1);
	wire sampleNow = (state_r == ST_WAIT) && eTick
		&& (phaseCnt_r == `CWD_SAMPLE_DELAY - 3'h1);
	wire release_w = (state_r == ST_HOLD) && pinFilt_r;
	wire [6:0] factor = rateFactor(watchdog_rate_sel);
	wire expire = baseTick && (tickCnt_r >= factor);
	wire wdogFire = inRun && expire && !nvDisable_r && !inhibit_r;
	wire extLow = inRun && !pinFilt_r;
	wire clkFail = inRun && clkMonFail;
	wire anyEvent = wdogFire || extLow || clkFail;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_DRIVE: begin
				if (phaseDone4) begin
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (sampleNow) begin
					state_nxt = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (pinFilt_r) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (anyEvent) begin
					state_nxt = ST_DRIVE;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_r <= ST_DRIVE;
			phaseCnt_r <= 3'h0;
		end else begin
			state_r <= state_nxt;
			if (state_nxt != state_r) begin
				phaseCnt_r <= 3'h0;
			end else if (eTick) begin
				phaseCnt_r <= phaseCnt_r + 3'h1;
			end
		end
	end

	// Open-drain style drive of the reset pin while in the drive phase
	assign resetPinOe = (state_r == ST_DRIVE);
	assign resetPinOut = 1'b0;
	assign sysReset_n = inRun;

	// ****************************************************************
	// Reset source
	// ****************************************************************
	wire cause_e_int = (pendCause_r == CAUSE_WDOG)
		|| (pendCause_r == CAUSE_CLKMON);
	wire cwd_cause_e sampledCause = !pinFilt_r ? CAUSE_EXT : pendCause_r;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pendCause_r <= CAUSE_NONE;
			cause_r <= CAUSE_NONE;
		end else begin
			if (inRun && anyEvent) begin
				pendCause_r <= clkFail ? CAUSE_CLKMON :
					(wdogFire ? CAUSE_WDOG : CAUSE_EXT);
			end
			if (sampleNow) begin
				cause_r <= sampledCause;
			end
		end
	end

	assign resetCause = cause_r;

	// ****************************************************************
	// Mode and configuration latched at release
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			specialMode_r <= 1'b0;
			nvDisable_r <= 1'b1;
		end else if (release_w) begin
			specialMode_r <= !modeFilt_r;
			nvDisable_r <= watchdog_disable_cfg;
		end
	end

	assign special_mode_flag = specialMode_r;

	// ****************************************************************
	// APB decode
	// ****************************************************************
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire hitRate = (paddr == `CWD_ADDR_RATE);
	wire hitTest = (paddr == `CWD_ADDR_TEST);
	wire hitSvc = (paddr == `CWD_ADDR_SERVICE);
	wire hitStat = (paddr == `CWD_ADDR_STATUS);
	wire hit = hitRate || hitTest || hitSvc || hitStat;
	wire wrEn = access && pwrite && hit && inRun;
	wire rateLocked = !specialMode_r
		&& (rateWritten_r || winCnt_r >= `CWD_RATE_WINDOW);
	wire rateWrite = wrEn && hitRate && !rateLocked;
	wire testWrite = wrEn && hitTest && specialMode_r;
	wire svcWrite = wrEn && hitSvc;
	wire svcDone = svcWrite && svcArmed_r
		&& (pwdata[7:0] == `CWD_SERVICE_KEY2);
	wire [31:0] statWord = {27'h0, rateLocked, !nvDisable_r,
		specialMode_r, cause_r};
	wire [31:0] rdMux = hitRate ? {30'h0, watchdog_rate_sel} :
		hitTest ? {31'h0, inhibit_r} :
		hitStat ? statWord : 32'h0;

	assign pready = 1'b1;
	assign pslverr = access && !hit;
	assign prdata = prdata_r;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			prdata_r <= 32'h0;
		end else if (setup) begin
			prdata_r <= pwrite ? 32'h0 : rdMux;
		end
	end

	// ****************************************************************
	// Rate select and its write window
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (sysRst) begin
			watchdog_rate_sel <= `CWD_RATE_RESET;
			rateWritten_r <= 1'b0;
			winCnt_r <= 7'h0;
		end else begin
			if (eTick && winCnt_r < `CWD_RATE_WINDOW) begin
				winCnt_r <= winCnt_r + 7'h1;
			end
			if (rateWrite) begin
				watchdog_rate_sel <= pwdata[1:0];
				rateWritten_r <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Test inhibit, set at release in special modes
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			inhibit_r <= 1'b0;
		end else if (release_w) begin
			inhibit_r <= !modeFilt_r;
		end else if (testWrite) begin
			inhibit_r <= pwdata[`CWD_TEST_INHIBIT_BIT];
		end
	end

	// ****************************************************************
	// Watchdog count and service
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (sysRst) begin
			tickCnt_r <= 7'h0;
			svcArmed_r <= 1'b0;
		end else begin
			if (svcWrite) begin
				svcArmed_r <= (pwdata[7:0] == `CWD_SERVICE_KEY1);
			end
			if (svcDone) begin
				tickCnt_r <= 7'h0;
			end else if (expire) begin
				tickCnt_r <= 7'h0;
			end else if (baseTick) begin
				tickCnt_r <= tickCnt_r + 7'h1;
			end
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	logic [2:0] driveTicks_r;
	always_ff @(posedge ref_clk) begin
		if (!reset_n || state_r != ST_DRIVE) begin
			driveTicks_r <= 3'h0;
		end else if (eTick) begin
			driveTicks_r <= driveTicks_r + 3'h1;
		end
	end

	drive_length_a: assert property (
		(state_r == ST_DRIVE && $past(state_r) == ST_DRIVE)
			|-> driveTicks_r <= 3'h4 && resetPinOe)
		else $error("reset pin drive longer than four cycles");

	drive_exit_a: assert property (
		(state_r == ST_WAIT && $past(state_r) == ST_DRIVE)
			|-> $past(driveTicks_r) == 3'h3 && !resetPinOe)
		else $error("reset pin released at wrong count");

	sample_ext_a: assert property (
		sampleNow && !pinFilt_r |=> cause_r == CAUSE_EXT)
		else $error("low pin not classed as external");

	sample_int_a: assert property (
		sampleNow && pinFilt_r && cause_e_int |=> cause_r == $past(pendCause_r))
		else $error("internal reset source lost");

	cfg_stable_a: assert property (
		inRun && $past(inRun) |-> $stable(nvDisable_r))
		else $error("watchdog enable changed without reset");

	test_inhibit_a: assert property (
		release_w && !modeFilt_r |=> inhibit_r && specialMode_r)
		else $error("special mode did not start inhibited");

	wdog_reset_a: assert property (
		wdogFire |=> state_r == ST_DRIVE ##1 resetPinOe)
		else $error("expiry did not start a reset");

	rate_reset_a: assert property (
		release_w |=> watchdog_rate_sel == 2'h0)
		else $error("rate select not cleared by reset");

	rate_lock_a: assert property (
		wrEn && hitRate && rateLocked |=> $stable(watchdog_rate_sel))
		else $error("locked rate select was written");

	// E ticks since last service or release
	logic [21:0] sinceSvc_r;
	always_ff @(posedge ref_clk) begin
		if (sysRst || svcDone) begin
			sinceSvc_r <= 22'h0;
		end else if (eTick && !(&sinceSvc_r)) begin
			sinceSvc_r <= sinceSvc_r + 22'h1;
		end
	end

	min_timeout_a: assert property (
		wdogFire |-> sinceSvc_r >= 22'(factor) * 22'(BASE_DIV))
		else $error("watchdog expired early");

	service_a: assert property (
		svcDone |=> tickCnt_r == 7'h0 && !svcArmed_r)
		else $error("service did not restart the count");

endmodule

/* File: verification/cwd_pin_model.sv */
// Reset pin wire with pull-up and an external reset source
module cwd_pin_model (
	input wire logic resetPinOe,
	input wire logic resetPinOut,
	input wire logic extHoldLow,
	output logic pinLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************
	// Wire level
	// ****************************************************
	// Strong pull-up, pin rises at once on release unless extHoldLow holds it low
	assign pinLevel = resetPinOe ? resetPinOut : !extHoldLow;
endmodule

/* File: verification/cwd_top_tb.sv */
// Self-checking bench for the reset-sense watchdog
`include "cwd_defs.svh"
module cwd_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cwd_pkg::*;
	// ****************************************************
	// Bench signals and instances
	// ****************************************************
	localparam int BD = 4;
	localparam int BB = 8;
	logic refClk = 0;
	logic resetN = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic err;
	logic pready;
	logic pslverr;
	logic pinOut;
	logic pinOe;
	logic pinLvl;
	logic modeB = 1;
	logic cfgDis = 1;
	logic clkFail = 0;
	logic extLow = 0;
	logic sysRstN;
	logic special;
	cwd_cause_e cause;
	int numErrors = 0;
	int checkCount = 0;
	int n;

	initial forever #2.5 refClk = ~refClk;

	cwd_top #(.BUS_DIV(BD), .BASE_DIV(BB)) dut_u (.ref_clk(refClk),
		.reset_n(resetN), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.resetPinIn(pinLvl), .resetPinOut(pinOut),
		.resetPinOe(pinOe), .mode_pin_b(modeB),
		.watchdog_disable_cfg(cfgDis), .clkMonFail(clkFail),
		.sysReset_n(sysRstN), .resetCause(cause),
		.special_mode_flag(special));
	cwd_pin_model pin_u (.resetPinOe(pinOe), .resetPinOut(pinOut),
		.extHoldLow(extLow), .pinLevel(pinLvl));

	// ****************************************************
	// Shared tasks
	// ****************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checkCount++;
		if (seen !== want) begin
			numErrors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", checkCount, numErrors);
		if (numErrors == 0 && checkCount > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge refClk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge refClk);
		penable <= 1;
		@(posedge refClk);
		while (pready !== 1'b1) @(posedge refClk);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic svc();
		apb(1, `CWD_ADDR_SERVICE, {24'h0, `CWD_SERVICE_KEY1});
		apb(1, `CWD_ADDR_SERVICE, {24'h0, `CWD_SERVICE_KEY2});
	endtask

	task automatic wait_run();
		while (sysRstN !== 1'b1) @(posedge refClk);
	endtask

	task automatic oe_len();
		n = 0;
		while (pinOe !== 1'b1) @(posedge refClk);
		while (pinOe === 1'b1) begin
			@(posedge refClk);
			n++;
		end
		check(n >= 3 * BD + 1 && n <= 4 * BD, 1);
	endtask

	// ****************************************************
	// Scenarios
	// ****************************************************
	task automatic t_power();
		wait_run();
		check(cause, CAUSE_NONE);
		check(special, 0);
		apb(0, `CWD_ADDR_RATE, 0);
		check(rd[1:0], `CWD_RATE_RESET);
		apb(0, `CWD_ADDR_STATUS, 0);
		check(rd[`CWD_STAT_ENABLED_BIT], 0);
		cfgDis <= 0;
		apb(0, 12'h020, 0);
		check(err, 1);
		apb(0, `CWD_ADDR_STATUS, 0);
		check(rd[`CWD_STAT_ENABLED_BIT], 0);
		repeat (200) @(posedge refClk);
		check(sysRstN, 1);
		$display("Test power done");
	endtask

	task automatic t_ext();
		extLow <= 1;
		oe_len();
		repeat (20) @(posedge refClk);
		extLow <= 0;
		wait_run();
		apb(1, `CWD_ADDR_RATE, 32'h3);
		svc();
		apb(1, `CWD_ADDR_RATE, 32'h1);
		apb(0, `CWD_ADDR_RATE, 0);
		check(rd[1:0], 2'h3);
		check(cause, CAUSE_EXT);
		apb(0, `CWD_ADDR_STATUS, 0);
		check(rd[`CWD_STAT_ENABLED_BIT], 1);
		$display("Test external done");
	endtask

	task automatic t_wdog(input int code);
		int f;
		f = 1 << (2 * code);
		svc();
		n = 0;
		while (sysRstN === 1'b1) begin
			@(posedge refClk);
			n++;
		end
		check(n > f * BB * BD, 1);
		check(n <= (f + 1) * BB * BD + 2 * BD, 1);
		oe_len();
		wait_run();
		check(cause, CAUSE_WDOG);
		apb(0, `CWD_ADDR_RATE, 0);
		check(rd[1:0], `CWD_RATE_RESET);
		$display("Test watchdog factor %0d done", f);
	endtask

	task automatic t_late();
		repeat (50) svc();
		apb(1, `CWD_ADDR_RATE, 32'h2);
		apb(0, `CWD_ADDR_RATE, 0);
		check(rd[1:0], 2'h0);
		$display("Test late write done");
	endtask

	task automatic t_clkmon();
		clkFail <= 1;
		@(posedge refClk);
		clkFail <= 0;
		while (sysRstN === 1'b1) @(posedge refClk);
		wait_run();
		check(cause, CAUSE_CLKMON);
		$display("Test clock monitor done");
	endtask

	task automatic t_special();
		modeB <= 0;
		resetN <= 0;
		repeat (16) @(posedge refClk);
		resetN <= 1;
		wait_run();
		check(special, 1);
		repeat (300) @(posedge refClk);
		check(sysRstN, 1);
		apb(1, `CWD_ADDR_TEST, 0);
		n = 0;
		while (sysRstN === 1'b1 && n < 100) begin
			@(posedge refClk);
			n++;
		end
		check(n <= 2 * BB * BD + 2 * BD, 1);
		$display("Test special mode done");
	endtask

	// ****************************************************
	// Main sequence and watchdog
	// ****************************************************
	initial begin
		repeat (16) @(posedge refClk);
		resetN <= 1;
		t_power();
		t_ext();
		t_wdog(3);
		t_wdog(0);
		t_late();
		t_clkmon();
		t_special();
		close_out();
	end

	initial begin
		repeat (30000) @(posedge refClk);
		numErrors++;
		close_out();
	end
endmodule
